// ### hdl/fiap_pkg.sv
package fiap_pkg;

    // ****************************************************************
    // register map, one aligned word per register
    // ****************************************************************
    localparam logic [3:0] IDX_MODE = 4'h0;
    localparam logic [3:0] IDX_KEY = 4'h1;
    localparam logic [3:0] IDX_CLEAR = 4'h2;
    localparam logic [3:0] IDX_ADDR_LO = 4'h3;
    localparam logic [3:0] IDX_ADDR_HI = 4'h4;
    localparam logic [3:0] IDX_D0_LO = 4'h5;
    localparam logic [3:0] IDX_D0_HI = 4'h6;
    localparam logic [3:0] IDX_D1_LO = 4'h7;
    localparam logic [3:0] IDX_D1_HI = 4'h8;
    localparam logic [3:0] IDX_D2_LO = 4'h9;
    localparam logic [3:0] IDX_D2_HI = 4'hA;
    localparam logic [3:0] IDX_D3_LO = 4'hB;
    localparam logic [3:0] IDX_D3_HI = 4'hC;
    localparam logic [3:0] IDX_LAST = 4'hC;
    // byte address bits above the register window must be zero
    localparam int SECTOR_LSB = 6;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 5;

    // ****************************************************************
    // field codes and constants
    // ****************************************************************
    localparam logic [2:0] MODE_WRITE = 3'h0;
    localparam logic [2:0] MODE_ERASE = 3'h1;
    localparam logic [2:0] MODE_READ = 3'h3;
    localparam logic [2:0] MODE_UNLOCK = 3'h6;
    localparam logic [7:0] KEY_CHIP_RESET = 8'h55;
    localparam logic [4:0] WORD_IDX_LAST = 5'h1F;
    localparam int PAGE_WORDS = 32;
    localparam int ADDR_HI_BITS = 5;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // unlock window; a timeout is a longest time, so it rounds down
    localparam int CLK_PERIOD_NS = 25;
    localparam int UNLOCK_TIME_NS = 10000;
    localparam logic [15:0] UNLOCK_CYCLES =
        16'(UNLOCK_TIME_NS / CLK_PERIOD_NS);

    // ****************************************************************
    // types
    // ****************************************************************
    // laid out exactly as the mode/handshake register bits 7..0
    typedef struct packed {
        logic enabled;
        logic [2:0] opMode;
        logic unlockTrig;
        logic writeStart;
        logic readEnable;
        logic readStart;
    } fiap_ctrl_t;

    typedef enum logic [1:0] {
        FL_NONE = 2'b00,
        FL_ERASE = 2'b01,
        FL_PROG = 2'b10,
        FL_READ = 2'b11
    } fiap_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CLEAR = 3'b001,
        ST_ERASE = 3'b010,
        ST_PROG = 3'b011,
        ST_READ = 3'b100
    } fiap_seq_t;

    typedef struct packed {
        logic valid;
        fiap_cmd_t cmd;
        logic [12:0] addr;
        logic [15:0] wdata;
    } fiap_flash_req_t;

    typedef struct packed {
        logic done;
        logic [15:0] rdata;
    } fiap_flash_rsp_t;

endpackage

// ### hdl/fiap_ctrl.sv
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
// Summary of operation
// [R1] erase/program by page, read one word
// [R2] page and write buffer are 32 words
// [R3] software erases a page before programming
// [R4] enabled status set by unlock, gates buffer
// [R5] write start held high until programming done
// [R6] read needs enable; start clears when done
// [R7] page from address bits 12..5, word 4..0
// [R8] buffer clear bit self-clears after clearing
// [R9] software clears buffer before first use
// [R10] buffer bound to page of bits 12..5
// [R11] first data low write stores only itself
// [R12] first data high write loads buffer, increments
// [R13] address increment stops at word 31
// [R14] buffer cleared after every programming run
// [R15] on verify failure software clears and reloads
// [R16] all registers decoded in sector zero
// [R17] high address bits 7..5 read zero
// [R18] address and data registers reset to zero
// [R19] mode codes: write, erase, read, unlock
// [R20] software may clear enabled status only
// [R21] unlock trigger starts timer, clears on timeout
// [R22] key 55H requests whole chip reset
// [R23] cpu stalled while an operation runs
module fiap_ctrl
    import fiap_pkg::*;
#(
    // arbitrary unlock pattern values, replace per product
    parameter logic [15:0] UNLOCK_PAT1 = 16'h1234,
    parameter logic [15:0] UNLOCK_PAT2 = 16'h5678,
    parameter logic [15:0] UNLOCK_PAT3 = 16'h9ABC
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // flash array port
    output fiap_flash_req_t flashReq,
    input wire fiap_flash_rsp_t flashRsp,
    // system side
    output logic cpuStall,
    output logic chipResetReq
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        fiap_ctrl_t ctrl;
        logic [7:0] key;
        logic clrBuf;
        logic [12:0] addr;
        logic [3:0][15:0] data;
        logic [PAGE_WORDS-1:0][15:0] wbuf;
        fiap_seq_t st;
        logic [4:0] idx;
        logic progClr;
        logic [15:0] timer;
        logic dpValid;
        logic dpWrite;
        logic dpHit;
        logic [3:0] dpIdx;
        logic rdDone;
        logic [31:0] rdata;
        logic chipRst;
    } fiap_state_t;

    fiap_state_t s_q;
    fiap_state_t s_d;
    logic [7:0] wbyte;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // register read mux, shared by the bus read path
    function automatic logic [7:0] regRead(fiap_state_t s,
                                            logic [3:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IDX_MODE: v = s.ctrl;
            IDX_KEY: v = s.key;
            IDX_CLEAR: v = {7'h00, s.clrBuf};
            IDX_ADDR_LO: v = s.addr[7:0];
            IDX_ADDR_HI: v = {3'h0, s.addr[12:8]}; // R17
            IDX_D0_LO: v = s.data[0][7:0];
            IDX_D0_HI: v = s.data[0][15:8];
            IDX_D1_LO: v = s.data[1][7:0];
            IDX_D1_HI: v = s.data[1][15:8];
            IDX_D2_LO: v = s.data[2][7:0];
            IDX_D2_HI: v = s.data[2][15:8];
            IDX_D3_LO: v = s.data[3][7:0];
            IDX_D3_HI: v = s.data[3][15:8];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // full flash word address from page number and word index
    function automatic logic [12:0] pageAddr(logic [12:0] a,
                                              logic [4:0] w);
        return {a[12:5], w}; // R7 R10
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        wbyte = hwdata[7:0];
        s_d.chipRst = 1'b0;

        // unlock window: patterns in pairs two..four within the timer
        if (s_q.ctrl.unlockTrig) begin
            if (s_q.ctrl.opMode == MODE_UNLOCK &&
                s_q.data[1] == UNLOCK_PAT1 &&
                s_q.data[2] == UNLOCK_PAT2 &&
                s_q.data[3] == UNLOCK_PAT3) begin
                s_d.ctrl.enabled = 1'b1; // R4
                s_d.ctrl.unlockTrig = 1'b0;
            end else if (s_q.timer == UNLOCK_CYCLES - 16'h0001) begin
                s_d.ctrl.unlockTrig = 1'b0; // R21
            end else begin
                s_d.timer = s_q.timer + 16'h0001; // R21
            end
        end

        // operation sequencer; hardware clears come before bus writes
        // so a software set in the same cycle wins
        case (s_q.st)
            ST_IDLE: begin
                s_d.idx = 5'h00;
                if (s_q.clrBuf) begin
                    s_d.st = ST_CLEAR; // R8
                end else if (s_q.ctrl.writeStart) begin
                    if (s_q.ctrl.enabled &&
                        s_q.ctrl.opMode == MODE_WRITE) begin
                        s_d.st = ST_PROG; // R5
                    end else if (s_q.ctrl.enabled &&
                                 s_q.ctrl.opMode == MODE_ERASE) begin
                        s_d.st = ST_ERASE; // R1
                    end else begin
                        s_d.ctrl.writeStart = 1'b0; // R19
                    end
                end else if (s_q.ctrl.readStart) begin
                    if (s_q.ctrl.readEnable &&
                        s_q.ctrl.opMode == MODE_READ) begin
                        s_d.st = ST_READ; // R6
                    end else begin
                        s_d.ctrl.readStart = 1'b0; // R6
                    end
                end
            end
            ST_CLEAR: begin
                // one word per cycle; 32 cycles for the whole buffer
                s_d.wbuf[s_q.idx] = 16'h0000; // R8 R14
                s_d.idx = s_q.idx + 5'h01;
                if (s_q.idx == WORD_IDX_LAST) begin
                    s_d.st = ST_IDLE;
                    s_d.progClr = 1'b0;
                    if (s_q.progClr) begin
                        s_d.ctrl.writeStart = 1'b0; // R5 R14
                    end else begin
                        s_d.clrBuf = 1'b0; // R8
                    end
                end
            end
            ST_ERASE: begin
                if (flashRsp.done) begin
                    s_d.ctrl.writeStart = 1'b0; // R5
                    s_d.st = ST_IDLE;
                end
            end
            ST_PROG: begin
                // all 32 buffered words go out, so a page is whole
                if (flashRsp.done) begin
                    s_d.idx = s_q.idx + 5'h01; // R2
                    if (s_q.idx == WORD_IDX_LAST) begin
                        s_d.st = ST_CLEAR; // R14
                        s_d.progClr = 1'b1;
                    end
                end
            end
            ST_READ: begin
                if (flashRsp.done) begin
                    s_d.data[0] = flashRsp.rdata; // R1
                    s_d.ctrl.readStart = 1'b0; // R6
                    s_d.st = ST_IDLE;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase

        // bus data phase: writes take effect here, zero wait
        if (s_q.dpValid && s_q.dpWrite && s_q.dpHit && hready) begin
            case (s_q.dpIdx)
                IDX_MODE: begin
                    s_d.ctrl.enabled = s_d.ctrl.enabled & wbyte[7]; // R20
                    s_d.ctrl.opMode = wbyte[6:4]; // R19
                    s_d.ctrl.readEnable = wbyte[1];
                    // start bits are set-only so a busy run is not cut
                    s_d.ctrl.writeStart = s_d.ctrl.writeStart | wbyte[2];
                    s_d.ctrl.readStart = s_d.ctrl.readStart | wbyte[0];
                    if (wbyte[3]) begin
                        s_d.ctrl.unlockTrig = 1'b1; // R21
                        s_d.timer = 16'h0000;
                    end
                end
                IDX_KEY: begin
                    s_d.key = wbyte;
                    s_d.chipRst = (wbyte == KEY_CHIP_RESET); // R22
                end
                IDX_CLEAR: s_d.clrBuf = s_d.clrBuf | wbyte[0]; // R8
                IDX_ADDR_LO: s_d.addr[7:0] = wbyte;
                IDX_ADDR_HI: begin
                    s_d.addr[12:8] = wbyte[ADDR_HI_BITS-1:0]; // R17
                end
                IDX_D0_LO: s_d.data[0][7:0] = wbyte; // R11
                IDX_D0_HI: begin
                    s_d.data[0][15:8] = wbyte;
                    // loads are refused while locked or while busy
                    if (s_q.ctrl.enabled && s_q.st == ST_IDLE) begin
                        s_d.wbuf[s_q.addr[4:0]] =
                            {wbyte, s_q.data[0][7:0]}; // R4 R12
                        if (s_q.addr[4:0] != WORD_IDX_LAST) begin
                            s_d.addr = s_q.addr + 13'h0001; // R12 R13
                        end
                    end
                end
                IDX_D1_LO: s_d.data[1][7:0] = wbyte;
                IDX_D1_HI: s_d.data[1][15:8] = wbyte;
                IDX_D2_LO: s_d.data[2][7:0] = wbyte;
                IDX_D2_HI: s_d.data[2][15:8] = wbyte;
                IDX_D3_LO: s_d.data[3][7:0] = wbyte;
                IDX_D3_HI: s_d.data[3][15:8] = wbyte;
                default: s_d.key = s_d.key;
            endcase
        end

        // read data phase: one wait cycle so the word comes from a flop
        // and sees any write that completed just before
        if (s_q.dpValid && !s_q.dpWrite && !s_q.rdDone) begin
            s_d.rdDone = 1'b1;
            s_d.rdata = 32'h0000_0000;
            if (s_q.dpHit) begin
                s_d.rdata[7:0] = regRead(s_q, s_q.dpIdx);
            end
        end

        // address phase capture
        if (hready) begin
            s_d.dpValid = hsel && htrans == HTRANS_NONSEQ;
            s_d.dpWrite = hwrite;
            s_d.dpIdx = haddr[IDX_MSB:IDX_LSB];
            s_d.dpHit = haddr[31:SECTOR_LSB] == '0 &&
                        haddr[IDX_MSB:IDX_LSB] <= IDX_LAST; // R16
            s_d.rdDone = 1'b0;
        end
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    // synchronous reset: everything, buffer included, comes up zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0; // R18
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // a read holds the bus for one wait state, writes never do
    assign hreadyout = !(s_q.dpValid && !s_q.dpWrite && !s_q.rdDone);
    assign hrdata = s_q.rdata;
    assign hresp = HRESP_OKAY;
    assign chipResetReq = s_q.chipRst; // R22

    // flash command held until the array answers done
    always_comb begin
        flashReq.valid = 1'b0;
        flashReq.cmd = FL_NONE;
        flashReq.addr = s_q.addr;
        flashReq.wdata = 16'h0000;
        case (s_q.st)
            ST_ERASE: begin
                flashReq.valid = 1'b1;
                flashReq.cmd = FL_ERASE;
                flashReq.addr = pageAddr(s_q.addr, 5'h00); // R1 R7
            end
            ST_PROG: begin
                flashReq.valid = 1'b1;
                flashReq.cmd = FL_PROG;
                flashReq.addr = pageAddr(s_q.addr, s_q.idx); // R10
                flashReq.wdata = s_q.wbuf[s_q.idx];
            end
            ST_READ: begin
                flashReq.valid = 1'b1;
                flashReq.cmd = FL_READ;
            end
            default: flashReq.valid = 1'b0;
        endcase
    end

    // the cpu waits until every start bit has dropped and the sequencer is back in ST_IDLE
    assign cpuStall = s_q.ctrl.writeStart || s_q.ctrl.readStart ||
                      s_q.st != ST_IDLE; // R23

    // hsize is not checked: only whole words are issued
    logic unusedSize;
    assign unusedSize = ^hsize;

endmodule

// ### dv/fiap_ctrl_properties.sv
`timescale 1ns/100ps
// ****************************************************************
// port checks for the programming controller
// ****************************************************************
module fiap_ctrl_properties
    import fiap_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // flash array and system
    input wire fiap_flash_req_t flashReq,
    input wire fiap_flash_rsp_t flashRsp,
    input wire logic cpuStall,
    input wire logic chipResetReq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic rdAddr;
    logic keyAddr;
    logic progDone;
    // accepted address phases and finished program words of interest
    assign rdAddr = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
    assign keyAddr = hsel && hready && htrans == HTRANS_NONSEQ && hwrite
        && haddr == 32'({IDX_KEY, 2'b00});
    assign progDone = flashReq.valid && flashReq.cmd == FL_PROG
        && flashRsp.done;
    // reset must win even though every other check is gated by it
    property p_rst;
        disable iff (1'b0) sys_rst |=> !flashReq.valid && !cpuStall
            && hreadyout && hrdata == 32'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("not idle after reset");
    property p_okay;
        hresp == HRESP_OKAY;
    endproperty
    a_okay: assert property (p_okay) else $error("bad response");
    property p_rdws;
        rdAddr |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rdws: assert property (p_rdws) else $error("read wait state");
    property p_hold;
        flashReq.valid && !flashRsp.done |=> flashReq.valid
            && $stable(flashReq.addr) && $stable(flashReq.wdata);
    endproperty
    a_hold: assert property (p_hold) else $error("request dropped");
    property p_stall;
        flashReq.valid |-> cpuStall && flashReq.cmd != FL_NONE;
    endproperty
    a_stall: assert property (p_stall) else $error("cpu not stalled");
    property p_step;
        progDone && flashReq.addr[4:0] != WORD_IDX_LAST |=> flashReq.valid
            && flashReq.addr == $past(flashReq.addr) + 13'h1;
    endproperty
    a_step: assert property (p_step) else $error("bad word step");
    property p_last;
        progDone && flashReq.addr[4:0] == WORD_IDX_LAST |=>
            (!flashReq.valid && cpuStall) [*8];
    endproperty
    a_last: assert property (p_last) else $error("page overrun");
    property p_key;
        keyAddr ##1 hwdata[7:0] == KEY_CHIP_RESET |-> ##[1:2] chipResetReq;
    endproperty
    a_key: assert property (p_key) else $error("no chip reset");
    property p_pulse;
        chipResetReq |=> !chipResetReq;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long reset pulse");
    c_prog: cover property (progDone);
    c_read: cover property (flashReq.cmd == FL_READ && flashRsp.done);
    c_key: cover property (chipResetReq);
endmodule
bind fiap_ctrl fiap_ctrl_properties u_chk (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .flashReq(flashReq), .flashRsp(flashRsp), .cpuStall(cpuStall),
    .chipResetReq(chipResetReq));

// ### dv/tb_top.sv
`timescale 1ns/100ps
module tb_top
    import fiap_pkg::*;
;
    // arbitrary unlock patterns
    localparam logic [15:0] PAT1 = 16'hC3A5;
    localparam logic [15:0] PAT2 = 16'h5E71;
    localparam logic [15:0] PAT3 = 16'h0BD6;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    fiap_flash_req_t flashReq;
    fiap_flash_rsp_t flashRsp = '0;
    logic cpuStall;
    logic chipResetReq;
    int n_fail = 0;
    int n_checks = 0;
    int nRst = 0;
    logic [30:0] expQ[$];
    logic [15:0] lastRd = 16'h0;
    logic [15:0] bufW[32];
    logic [15:0] pats[3] = '{PAT1, PAT2, PAT3};
    logic [1:0] dly = 2'h0;
    logic [7:0] page;
    logic [7:0] v;
    logic [31:0] seen;

    always #12.5 clk = ~clk;

    fiap_ctrl #(.UNLOCK_PAT1(PAT1), .UNLOCK_PAT2(PAT2), .UNLOCK_PAT3(PAT3))
    dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .flashReq(flashReq), .flashRsp(flashRsp),
        .cpuStall(cpuStall), .chipResetReq(chipResetReq));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] ad(input logic [3:0] i);
        return 32'({i, 2'b00});
    endfunction

    // one single transfer; entered right after an edge
    task automatic xfer(input logic [31:0] a, input logic w,
        input logic [7:0] d, output logic [7:0] q);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'($urandom), d}; // upper bits must be ignored
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        q = hrdata[7:0];
    endtask

    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        logic [7:0] q;
        xfer(ad(i), 1'b1, d, q);
    endtask

    task automatic rdc(input logic [3:0] i, input logic [7:0] e);
        logic [7:0] q;
        xfer(ad(i), 1'b0, 8'h0, q);
        chk(32'(q), 32'(e));
    endtask

    // poll until the masked self-clearing bits drop, bounded
    task automatic pw(input logic [3:0] i, input logic [7:0] m);
        logic [7:0] q;
        for (int k = 0; k < 300; k++) begin
            xfer(ad(i), 1'b0, 8'h0, q);
            if ((q & m) == 8'h0) break;
        end
        chk(32'(q & m), 32'h0);
    endtask

    // ****************************************************************
    // flash array stand-in and result watcher
    // ****************************************************************
    // random answer delay; rdata churns so a stale word cannot pass
    always @(posedge clk) begin
        flashRsp.done <= flashReq.valid && !flashRsp.done && dly == 2'h0;
        flashRsp.rdata <= 16'($urandom);
        if (flashReq.valid && !flashRsp.done)
            dly <= (dly == 2'h0) ? 2'($urandom) : dly - 2'h1;
    end

    // data word only matters for programming commands
    assign seen = {1'b0, flashReq.cmd, flashReq.addr,
        flashReq.cmd == FL_PROG ? flashReq.wdata : 16'h0};
    always @(posedge clk) begin
        if (!sys_rst && flashReq.valid && flashRsp.done) begin
            if (flashReq.cmd == FL_READ) lastRd <= flashRsp.rdata;
            chk(32'(expQ.size() != 0), 32'h1);
            if (expQ.size() != 0) chk(seen, 32'(expQ.pop_front()));
        end
    end

    // every array command must hold the cpu; reset pulses are counted
    always @(posedge clk) begin
        if (chipResetReq === 1'b1) nRst++;
        if (!sys_rst && flashReq.valid && flashRsp.done)
            chk(32'(cpuStall), 32'h1);
    end

    // watchdog, far beyond the thousand or so cycles the tests need
    initial begin
        #(25 * 20000);
        n_fail++;
        wrap_up();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [15:0] w;
        void'($urandom(95866));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i <= int'(IDX_LAST); i++) rdc(4'(i), 8'h00);
        xfer(32'h40, 1'b1, 8'hFF, v);
        xfer(32'h40, 1'b0, 8'h00, v);
        chk(32'(v), 32'h0);
        wr(IDX_ADDR_HI, 8'hFF);
        rdc(IDX_ADDR_HI, 8'h1F);
        wr(IDX_ADDR_HI, 8'h00);
        wr(IDX_D0_LO, 8'hA5);
        wr(IDX_D0_HI, 8'h5A);
        rdc(IDX_ADDR_LO, 8'h00);
        rdc(IDX_D0_LO, 8'hA5);
        wr(IDX_MODE, 8'h04);
        pw(IDX_MODE, 8'h04);
        // wrong patterns: trigger waits out its timer
        wr(IDX_MODE, 8'h68);
        rdc(IDX_MODE, 8'h68);
        pw(IDX_MODE, 8'h08);
        for (int i = 0; i < 3; i++) begin
            wr(4'(int'(IDX_D1_LO) + 2 * i), pats[i][7:0]);
            wr(4'(int'(IDX_D1_HI) + 2 * i), pats[i][15:8]);
        end
        wr(IDX_MODE, 8'h68);
        rdc(IDX_MODE, 8'hE0);
        wr(IDX_CLEAR, 8'h01);
        rdc(IDX_CLEAR, 8'h01);
        pw(IDX_CLEAR, 8'h01);
        // erase a random page; mode writes keep bit 7 set
        page = 8'($urandom);
        wr(IDX_ADDR_HI, {3'h0, page[7:3]});
        wr(IDX_ADDR_LO, {page[2:0], 5'h00});
        expQ.push_back({FL_ERASE, page, 5'h00, 16'h0});
        wr(IDX_MODE, 8'h94);
        pw(IDX_MODE, 8'h04);
        // 33 loads: the last overwrites word 31
        for (int i = 0; i < 33; i++) begin
            w = 16'($urandom);
            bufW[(i > 31) ? 31 : i] = w;
            wr(IDX_D0_LO, w[7:0]);
            wr(IDX_D0_HI, w[15:8]);
        end
        rdc(IDX_ADDR_LO, {page[2:0], 5'h1F});
        rdc(IDX_ADDR_HI, {3'h0, page[7:3]});
        // second run must see the buffer emptied by the first
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < PAGE_WORDS; i++)
                expQ.push_back({FL_PROG, page, 5'(i), k == 0 ? bufW[i] : 16'h0});
            wr(IDX_MODE, 8'h84);
            rdc(IDX_MODE, 8'h84);
            pw(IDX_MODE, 8'h04);
        end
        wr(IDX_MODE, 8'hB2);
        expQ.push_back({FL_READ, page, 5'h1F, 16'h0});
        wr(IDX_MODE, 8'hB3);
        pw(IDX_MODE, 8'h01);
        rdc(IDX_D0_LO, lastRd[7:0]);
        rdc(IDX_D0_HI, lastRd[15:8]);
        wr(IDX_MODE, 8'hB1);
        pw(IDX_MODE, 8'h01);
        wr(IDX_KEY, KEY_CHIP_RESET);
        wr(IDX_MODE, 8'h00);
        chk(32'(nRst), 32'h1);
        rdc(IDX_MODE, 8'h00);
        wr(IDX_MODE, 8'h80);
        rdc(IDX_MODE, 8'h00);
        chk(32'(expQ.size()), 32'h0);
        wrap_up();
    end
endmodule
